/* sdcd_pkg.sv */
// sdcd_pkg: constants, register map and types of the delta-sigma
// clock generator and sinc3 decimator.
// assumes a single 40 MHz system clock and an AXI4-Lite register bus.
package sdcd_pkg;

	// ***********************************************************
	// modes and configuration layout
	// ***********************************************************
	typedef enum logic [1:0] {
		SDCD_ANALOG_MODE,
		SDCD_CLOCK_OUT_MODE,
		SDCD_CLOCK_IN_MODE,
		SDCD_COMPARATOR_FEEDBACK_MODE
	} sdcd_mode_t;

	typedef struct packed {
		logic data_inv;
		logic clk_inv;
		sdcd_mode_t mode;
	} sdcd_modulator_mode_config_t;

	localparam int unsigned CFG_W = 4;
	localparam int unsigned NUM_GRP = 2;
	localparam int unsigned GRP_A = 0;
	localparam int unsigned GRP_B = 1;

	// ***********************************************************
	// widths
	// ***********************************************************
	localparam int unsigned FREQ_W = 32;
	localparam int unsigned RAW_W = 16;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 8;
	// bit of the phase accumulator that forms the clock: one period
	// per 2^31 of accumulated phase
	localparam int unsigned PHASE_BIT = 30;

	// ***********************************************************
	// register map (byte addresses)
	// ***********************************************************
	localparam logic [ADDR_W-1:0] OFS_GROUP_A_MODE_SETTING = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_GROUP_B_MODE_SETTING = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_GROUP_A_CLOCK_FREQUENCY = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_GROUP_B_CLOCK_FREQUENCY = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_GROUP_A_DECIMATION = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_GROUP_B_DECIMATION = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_RAW_BASE = 8'h40;

	// ***********************************************************
	// reset values
	// ***********************************************************
	localparam sdcd_modulator_mode_config_t RST_MODE = '{
		data_inv: 1'b0, clk_inv: 1'b0, mode: SDCD_ANALOG_MODE};
	localparam logic [FREQ_W-1:0] RST_FREQ = 32'h2000_0000;
	localparam int unsigned RST_DEC = 331;

	// ***********************************************************
	// bus answers
	// ***********************************************************
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : sdcd_pkg

/* sdcd_top.sv */
// sdcd_top: two-group modulator clock generation, pin steering and
// per-channel sinc3 decimation with an AXI4-Lite register slave.
// assumes pins are asynchronous to MCLK_I; the internal modulator bit
// stream arrives synchronous to MCLK_I.
//
// Behaviour
// - each group selects internal, clock-out, clock-in or comparator mode.
// - internal mode leaves clock pin undriven, uses internal modulator bits.
// - clock-out mode drives generated clock, samples channel pin data.
// - clock-in mode samples channel data on the received pin clock.
// - comparator mode drives feedback on clock pin, reads comparator bit.
// - mode setting also selects clock polarity and data polarity.
// - groups A and B hold separate mode, frequency and decimation.
// - generated frequency is system clock times parameter over 2^31.
// - frequency parameter is 32 bits wide.
// - quarter and eighth parameter values give jitter-free clocks.
// - each channel bit stream passes a third-order sinc filter.
// - one raw sample per decimation-ratio modulator clock pulses.
// - each raw sample is a 16-bit unsigned value.
// - filter step response lasts 3*(ratio-1)+1 modulator periods.
// - decimation ratio may change in operation, used for next samples.
// - channels split into two groups with their own sample rates.
// - external modes take the channel pin as a digital bit input.
//
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
module sdcd_top #(
	parameter int unsigned NCH = 8,
	parameter logic [NCH-1:0] GRP_B_MASK = 8'hE0,
	parameter int unsigned DEC_W = 10
) (
	input wire logic MCLK_I,
	input wire logic SYS_RST_I,
	input wire logic [sdcd_pkg::ADDR_W-1:0] AXI_AWADDR_I,
	input wire logic AXI_AWVALID_I,
	output logic AXI_AWREADY_O,
	input wire logic [sdcd_pkg::DATA_W-1:0] AXI_WDATA_I,
	input wire logic [3:0] AXI_WSTRB_I,
	input wire logic AXI_WVALID_I,
	output logic AXI_WREADY_O,
	output logic [1:0] AXI_BRESP_O,
	output logic AXI_BVALID_O,
	input wire logic AXI_BREADY_I,
	input wire logic [sdcd_pkg::ADDR_W-1:0] AXI_ARADDR_I,
	input wire logic AXI_ARVALID_I,
	output logic AXI_ARREADY_O,
	output logic [sdcd_pkg::DATA_W-1:0] AXI_RDATA_O,
	output logic [1:0] AXI_RRESP_O,
	output logic AXI_RVALID_O,
	input wire logic AXI_RREADY_I,
	input wire logic [NCH-1:0] CHANNEL_INPUT_PIN_I,
	input wire logic [NCH-1:0] INT_MOD_BIT_I,
	input wire logic [NCH-1:0] MOD_CLK_PIN_I,
	output logic [NCH-1:0] MOD_CLK_PIN_O,
	output logic [NCH-1:0] MOD_CLK_PIN_OE_O,
	output logic [NCH*sdcd_pkg::RAW_W-1:0] RAW_SAMPLE_O,
	output logic [NCH-1:0] SAMPLE_STROBE_O
);

	localparam int unsigned ACC_W = 3 * DEC_W + 1;
	localparam int unsigned WIDE_W = ACC_W + sdcd_pkg::RAW_W;
	localparam int unsigned SH_W = 6;
	localparam logic [DEC_W-1:0] DEC_ONE = DEC_W'(1);
	localparam logic [DEC_W-1:0] DEC_RST = DEC_W'(sdcd_pkg::RST_DEC);
	localparam logic [SH_W-1:0] RAW_SH = SH_W'(sdcd_pkg::RAW_W);
	localparam logic [WIDE_W-1:0] RAW_MAX = WIDE_W'(17'h0_FFFF);

	// ***********************************************************
	// helpers
	// ***********************************************************
	function automatic logic [sdcd_pkg::DATA_W-1:0] merge(
		input logic [sdcd_pkg::DATA_W-1:0] old_v,
		input logic [sdcd_pkg::DATA_W-1:0] new_v,
		input logic [3:0] strb);
		logic [sdcd_pkg::DATA_W-1:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// bits needed to hold values below the ratio, for output scaling
	function automatic logic [SH_W-1:0] ceil_log2(
		input logic [DEC_W-1:0] v);
		logic [SH_W-1:0] k;
		k = '0;
		for (int i = 0; i < DEC_W; i++) begin
			if ((DEC_W'(1) << i) < v) begin
				k = SH_W'(i + 1);
			end
		end
		return k;
	endfunction : ceil_log2

	// ***********************************************************
	// AXI4-Lite write path
	// ***********************************************************
	logic aw_got;
	logic w_got;
	logic [sdcd_pkg::ADDR_W-1:0] aw_addr;
	logic [sdcd_pkg::DATA_W-1:0] w_data;
	logic [3:0] w_strb;
	logic wr_fire;
	logic wr_hit;

	assign AXI_AWREADY_O = !aw_got && !AXI_BVALID_O;
	assign AXI_WREADY_O = !w_got && !AXI_BVALID_O;
	assign wr_fire = aw_got && w_got && !AXI_BVALID_O;

	always_comb begin
		case (aw_addr)
			sdcd_pkg::OFS_GROUP_A_MODE_SETTING,
			sdcd_pkg::OFS_GROUP_B_MODE_SETTING,
			sdcd_pkg::OFS_GROUP_A_CLOCK_FREQUENCY,
			sdcd_pkg::OFS_GROUP_B_CLOCK_FREQUENCY,
			sdcd_pkg::OFS_GROUP_A_DECIMATION,
			sdcd_pkg::OFS_GROUP_B_DECIMATION: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
			AXI_BVALID_O <= 1'b0;
			AXI_BRESP_O <= sdcd_pkg::RESP_OKAY;
		end else begin
			if (AXI_AWVALID_I && AXI_AWREADY_O) begin
				aw_got <= 1'b1;
				aw_addr <= AXI_AWADDR_I;
			end
			if (AXI_WVALID_I && AXI_WREADY_O) begin
				w_got <= 1'b1;
				w_data <= AXI_WDATA_I;
				w_strb <= AXI_WSTRB_I;
			end
			if (wr_fire) begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
				AXI_BVALID_O <= 1'b1;
				AXI_BRESP_O <= wr_hit ? sdcd_pkg::RESP_OKAY :
					sdcd_pkg::RESP_SLVERR;
			end else if (AXI_BVALID_O && AXI_BREADY_I) begin
				AXI_BVALID_O <= 1'b0;
			end
		end
	end

	// ***********************************************************
	// per-group settings
	// ***********************************************************
	sdcd_pkg::sdcd_modulator_mode_config_t cfg [sdcd_pkg::NUM_GRP];
	logic [sdcd_pkg::FREQ_W-1:0] freq [sdcd_pkg::NUM_GRP];
	logic [DEC_W-1:0] dec [sdcd_pkg::NUM_GRP];
	logic [sdcd_pkg::FREQ_W-1:0] phase [sdcd_pkg::NUM_GRP];
	logic [sdcd_pkg::NUM_GRP-1:0] phase_bit_d;
	logic [sdcd_pkg::NUM_GRP-1:0] gen_clk;
	logic [sdcd_pkg::NUM_GRP-1:0] gen_edge;

	for (genvar g = 0; g < sdcd_pkg::NUM_GRP; g++) begin : g_grp
		localparam logic [sdcd_pkg::ADDR_W-1:0] OM = (g == 0) ?
			sdcd_pkg::OFS_GROUP_A_MODE_SETTING :
			sdcd_pkg::OFS_GROUP_B_MODE_SETTING;
		localparam logic [sdcd_pkg::ADDR_W-1:0] OF = (g == 0) ?
			sdcd_pkg::OFS_GROUP_A_CLOCK_FREQUENCY :
			sdcd_pkg::OFS_GROUP_B_CLOCK_FREQUENCY;
		localparam logic [sdcd_pkg::ADDR_W-1:0] OD = (g == 0) ?
			sdcd_pkg::OFS_GROUP_A_DECIMATION :
			sdcd_pkg::OFS_GROUP_B_DECIMATION;
		logic [sdcd_pkg::DATA_W-1:0] wv_cfg;
		logic [sdcd_pkg::DATA_W-1:0] wv_freq;
		logic [sdcd_pkg::DATA_W-1:0] wv_dec;

		assign wv_cfg = merge(32'(cfg[g]), w_data, w_strb);
		assign wv_freq = merge(freq[g], w_data, w_strb);
		assign wv_dec = merge(32'(dec[g]), w_data, w_strb);

		// separate settings per group, defaults suit internal modulators
		always_ff @(posedge MCLK_I) begin
			if (SYS_RST_I) begin
				cfg[g] <= sdcd_pkg::RST_MODE;
				freq[g] <= sdcd_pkg::RST_FREQ;
				dec[g] <= DEC_RST;
			end else if (wr_fire) begin
				if (aw_addr == OM) begin
					cfg[g] <= wv_cfg[sdcd_pkg::CFG_W-1:0];
				end
				if (aw_addr == OF) begin
					freq[g] <= wv_freq;
				end
				if (aw_addr == OD) begin
					dec[g] <= wv_dec[DEC_W-1:0];
				end
			end
		end

		// phase accumulator: period is 2^31/freq cycles, so quarter and
		// eighth settings divide exactly and carry no jitter
		always_ff @(posedge MCLK_I) begin
			if (SYS_RST_I) begin
				phase[g] <= '0;
				phase_bit_d[g] <= 1'b0;
			end else begin
				phase[g] <= phase[g] + freq[g];
				phase_bit_d[g] <= gen_clk[g];
			end
		end

		assign gen_clk[g] = phase[g][sdcd_pkg::PHASE_BIT] ^ cfg[g].clk_inv;
		assign gen_edge[g] = gen_clk[g] && !phase_bit_d[g];
	end

	// ***********************************************************
	// AXI4-Lite read path
	// ***********************************************************
	logic [sdcd_pkg::RAW_W-1:0] raw [NCH];
	logic [sdcd_pkg::DATA_W-1:0] rd_val;
	logic rd_hit;

	always_comb begin
		rd_val = '0;
		rd_hit = 1'b1;
		case (AXI_ARADDR_I)
			sdcd_pkg::OFS_GROUP_A_MODE_SETTING:
				rd_val = 32'(cfg[sdcd_pkg::GRP_A]);
			sdcd_pkg::OFS_GROUP_B_MODE_SETTING:
				rd_val = 32'(cfg[sdcd_pkg::GRP_B]);
			sdcd_pkg::OFS_GROUP_A_CLOCK_FREQUENCY:
				rd_val = freq[sdcd_pkg::GRP_A];
			sdcd_pkg::OFS_GROUP_B_CLOCK_FREQUENCY:
				rd_val = freq[sdcd_pkg::GRP_B];
			sdcd_pkg::OFS_GROUP_A_DECIMATION:
				rd_val = 32'(dec[sdcd_pkg::GRP_A]);
			sdcd_pkg::OFS_GROUP_B_DECIMATION:
				rd_val = 32'(dec[sdcd_pkg::GRP_B]);
			default: begin
				rd_hit = 1'b0;
				for (int c = 0; c < NCH; c++) begin
					if (AXI_ARADDR_I == sdcd_pkg::OFS_RAW_BASE +
						sdcd_pkg::ADDR_W'(4 * c)) begin
						rd_hit = 1'b1;
						rd_val = 32'(raw[c]);
					end
				end
			end
		endcase
	end

	assign AXI_ARREADY_O = !AXI_RVALID_O;

	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I) begin
			AXI_RVALID_O <= 1'b0;
			AXI_RDATA_O <= '0;
			AXI_RRESP_O <= sdcd_pkg::RESP_OKAY;
		end else if (AXI_ARVALID_I && AXI_ARREADY_O) begin
			AXI_RVALID_O <= 1'b1;
			AXI_RDATA_O <= rd_val;
			AXI_RRESP_O <= rd_hit ? sdcd_pkg::RESP_OKAY :
				sdcd_pkg::RESP_SLVERR;
		end else if (AXI_RVALID_O && AXI_RREADY_I) begin
			AXI_RVALID_O <= 1'b0;
		end
	end

	// ***********************************************************
	// channels: pin steering and sinc3 decimation
	// ***********************************************************
	for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
		localparam int unsigned G = GRP_B_MASK[ch] ? 1 : 0;
		sdcd_pkg::sdcd_mode_t mode;
		logic in_s1, in_s2;
		logic clk_s1, clk_s2, clk_s3;
		logic rx_edge;
		logic pulse;
		logic bit_in;
		logic fb;
		logic tick;
		logic [DEC_W-1:0] ratio;
		logic [DEC_W-1:0] cnt;
		logic [ACC_W-1:0] i1, i2, i3;
		logic [ACC_W-1:0] z1, z2, z3;
		logic [ACC_W-1:0] c1, c2, c3;
		logic [SH_W-1:0] bits3;
		logic [WIDE_W-1:0] scaled;

		assign mode = cfg[G].mode;

		// pins are asynchronous: two flops before anything reads them
		always_ff @(posedge MCLK_I) begin
			if (SYS_RST_I) begin
				in_s1 <= 1'b0;
				in_s2 <= 1'b0;
				clk_s1 <= 1'b0;
				clk_s2 <= 1'b0;
				clk_s3 <= 1'b0;
			end else begin
				in_s1 <= CHANNEL_INPUT_PIN_I[ch];
				in_s2 <= in_s1;
				clk_s1 <= MOD_CLK_PIN_I[ch];
				clk_s2 <= clk_s1;
				clk_s3 <= clk_s2;
			end
		end

		// received clock is oversampled, so it must stay below half
		// the system clock rate
		assign rx_edge = (clk_s2 ^ cfg[G].clk_inv) &&
			!(clk_s3 ^ cfg[G].clk_inv);
		assign pulse = (mode == sdcd_pkg::SDCD_CLOCK_IN_MODE) ?
			rx_edge : gen_edge[G];
		assign bit_in = ((mode == sdcd_pkg::SDCD_ANALOG_MODE) ?
			INT_MOD_BIT_I[ch] : in_s2) ^ cfg[G].data_inv;

		// comparator feedback: latched comparator level each clock
		always_ff @(posedge MCLK_I) begin
			if (SYS_RST_I) begin
				fb <= 1'b0;
			end else if (pulse) begin
				fb <= in_s2;
			end
		end

		always_comb begin
			case (mode)
				sdcd_pkg::SDCD_CLOCK_OUT_MODE: begin
					MOD_CLK_PIN_OE_O[ch] = 1'b1;
					MOD_CLK_PIN_O[ch] = gen_clk[G];
				end
				sdcd_pkg::SDCD_COMPARATOR_FEEDBACK_MODE: begin
					MOD_CLK_PIN_OE_O[ch] = 1'b1;
					MOD_CLK_PIN_O[ch] = fb;
				end
				default: begin
					MOD_CLK_PIN_OE_O[ch] = 1'b0;
					MOD_CLK_PIN_O[ch] = 1'b0;
				end
			endcase
		end

		// a ratio of zero acts as one; a new ratio applies to the current
		// frame, ending it early or lengthening it, never stalls it
		assign ratio = (dec[G] == '0) ? DEC_ONE : dec[G];
		assign tick = pulse && (cnt >= ratio - DEC_ONE);

		always_ff @(posedge MCLK_I) begin
			if (SYS_RST_I) begin
				cnt <= '0;
			end else if (tick) begin
				cnt <= '0;
			end else if (pulse) begin
				cnt <= cnt + DEC_ONE;
			end
		end

		// integrators run at the modulator rate; wrap-around is harmless
		// because the differentiators cancel it
		always_ff @(posedge MCLK_I) begin
			if (SYS_RST_I) begin
				i1 <= '0;
				i2 <= '0;
				i3 <= '0;
			end else if (pulse) begin
				i1 <= i1 + ACC_W'(bit_in);
				i2 <= i2 + i1;
				i3 <= i3 + i2;
			end
		end

		assign c1 = i3 - z1;
		assign c2 = c1 - z2;
		assign c3 = c2 - z3;

		// full scale is ratio^3; shift to 16 bits, saturating the top
		// code, so resolution is exact only for power-of-two ratios
		assign bits3 = SH_W'(3) * ceil_log2(ratio);
		assign scaled = (bits3 >= RAW_SH) ?
			(WIDE_W'(c3) >> (bits3 - RAW_SH)) :
			(WIDE_W'(c3) << (RAW_SH - bits3));

		always_ff @(posedge MCLK_I) begin
			if (SYS_RST_I) begin
				z1 <= '0;
				z2 <= '0;
				z3 <= '0;
				raw[ch] <= '0;
				SAMPLE_STROBE_O[ch] <= 1'b0;
			end else begin
				SAMPLE_STROBE_O[ch] <= tick;
				if (tick) begin
					z1 <= i3;
					z2 <= c1;
					z3 <= c2;
					raw[ch] <= (scaled > RAW_MAX) ? RAW_MAX[15:0] :
						scaled[sdcd_pkg::RAW_W-1:0];
				end
			end
		end

		assign RAW_SAMPLE_O[ch*sdcd_pkg::RAW_W +: sdcd_pkg::RAW_W] = raw[ch];
	end

endmodule : sdcd_top

/* sdcd_top_asserts.sv */
// sdcd_top_asserts: port-level properties of sdcd_top.
// assumes one clock domain, MCLK_I, with synchronous SYS_RST_I.
`timescale 1ns/10ps
module sdcd_top_asserts #(
	parameter int unsigned NCH = 8
) (
	input wire logic MCLK_I,
	input wire logic SYS_RST_I,
	input wire logic AXI_AWVALID_I,
	input wire logic AXI_AWREADY_O,
	input wire logic AXI_WVALID_I,
	input wire logic AXI_WREADY_O,
	input wire logic AXI_BVALID_O,
	input wire logic AXI_BREADY_I,
	input wire logic [1:0] AXI_BRESP_O,
	input wire logic AXI_ARVALID_I,
	input wire logic AXI_ARREADY_O,
	input wire logic AXI_RVALID_O,
	input wire logic AXI_RREADY_I,
	input wire logic [sdcd_pkg::DATA_W-1:0] AXI_RDATA_O,
	input wire logic [NCH-1:0] MOD_CLK_PIN_O,
	input wire logic [NCH-1:0] MOD_CLK_PIN_OE_O,
	input wire logic [NCH*sdcd_pkg::RAW_W-1:0] RAW_SAMPLE_O,
	input wire logic [NCH-1:0] SAMPLE_STROBE_O
);
	default clocking cb @(posedge MCLK_I);
	endclocking
	default disable iff (SYS_RST_I);

	property p_wr_resp;
		AXI_AWVALID_I && AXI_AWREADY_O && AXI_WVALID_I && AXI_WREADY_O
			|-> ##[1:2] AXI_BVALID_O;
	endproperty
	a_wr_resp: assert property (p_wr_resp)
		else $error("write not answered");
	property p_rd_resp;
		AXI_ARVALID_I && AXI_ARREADY_O |=> AXI_RVALID_O;
	endproperty
	a_rd_resp: assert property (p_rd_resp)
		else $error("read not answered");
	property p_b_hold;
		AXI_BVALID_O && !AXI_BREADY_I |=> AXI_BVALID_O && $stable(AXI_BRESP_O);
	endproperty
	a_b_hold: assert property (p_b_hold)
		else $error("write response dropped");
	property p_r_hold;
		AXI_RVALID_O && !AXI_RREADY_I |=> AXI_RVALID_O && $stable(AXI_RDATA_O);
	endproperty
	a_r_hold: assert property (p_r_hold)
		else $error("read data dropped");
	property p_b_block;
		AXI_BVALID_O |-> !AXI_AWREADY_O && !AXI_WREADY_O;
	endproperty
	a_b_block: assert property (p_b_block)
		else $error("write taken while answer pending");
	property p_pin_idle;
		(MOD_CLK_PIN_O & ~MOD_CLK_PIN_OE_O) == '0;
	endproperty
	a_pin_idle: assert property (p_pin_idle)
		else $error("clock pin driven while released");
	property p_strobe_pulse;
		|SAMPLE_STROBE_O |=> (SAMPLE_STROBE_O & $past(SAMPLE_STROBE_O)) == '0;
	endproperty
	a_strobe_pulse: assert property (p_strobe_pulse)
		else $error("strobe longer than one cycle");
	property p_raw_hold;
		!SAMPLE_STROBE_O[0] |-> $stable(RAW_SAMPLE_O[15:0]);
	endproperty
	a_raw_hold: assert property (p_raw_hold)
		else $error("raw sample moved without strobe");
	property p_reset;
		$fell(SYS_RST_I) |-> !AXI_BVALID_O && !AXI_RVALID_O
			&& MOD_CLK_PIN_OE_O == '0 && RAW_SAMPLE_O == '0;
	endproperty
	a_reset: assert property (p_reset)
		else $error("state not cleared by reset");

	c_strobe: cover property (SAMPLE_STROBE_O[0]);
	c_write: cover property (AXI_BVALID_O && AXI_BREADY_I);
	c_pin_on: cover property (MOD_CLK_PIN_OE_O[0]);
endmodule : sdcd_top_asserts

bind sdcd_top sdcd_top_asserts #(.NCH(NCH)) u_asserts (
	.MCLK_I(MCLK_I), .SYS_RST_I(SYS_RST_I),
	.AXI_AWVALID_I(AXI_AWVALID_I), .AXI_AWREADY_O(AXI_AWREADY_O),
	.AXI_WVALID_I(AXI_WVALID_I), .AXI_WREADY_O(AXI_WREADY_O),
	.AXI_BVALID_O(AXI_BVALID_O), .AXI_BREADY_I(AXI_BREADY_I),
	.AXI_BRESP_O(AXI_BRESP_O), .AXI_ARVALID_I(AXI_ARVALID_I),
	.AXI_ARREADY_O(AXI_ARREADY_O), .AXI_RVALID_O(AXI_RVALID_O),
	.AXI_RREADY_I(AXI_RREADY_I), .AXI_RDATA_O(AXI_RDATA_O),
	.MOD_CLK_PIN_O(MOD_CLK_PIN_O), .MOD_CLK_PIN_OE_O(MOD_CLK_PIN_OE_O),
	.RAW_SAMPLE_O(RAW_SAMPLE_O), .SAMPLE_STROBE_O(SAMPLE_STROBE_O));

/* sdcd_mod_model.sv */
// sdcd_mod_model: external single-bit modulators, one per channel.
// assumes the bench resolves the shared clock pin level.
`timescale 1ns/10ps
module sdcd_mod_model #(
	parameter int unsigned NCH = 8,
	parameter int unsigned HALF_NS = 115
) (
	input wire logic [NCH-1:0] dev_clk_i,
	input wire logic own_clk_en_i,
	input wire logic cmp_en_i,
	input wire logic [NCH-1:0] level_i,
	output logic [NCH-1:0] clk_o,
	output logic [NCH-1:0] data_o
);
	logic [NCH-1:0] bit_q;
	// own clock stands still at 0 while no conversion runs
	initial begin
		clk_o = '0;
		bit_q = '0;
		forever begin
			#HALF_NS;
			clk_o = own_clk_en_i ? ~clk_o : '0;
		end
	end
	for (genvar i = 0; i < NCH; i++) begin : g_ch
		wire logic ck = own_clk_en_i ? clk_o[i] : dev_clk_i[i];
		always @(negedge ck) bit_q[i] <= level_i[i];
	end
	// comparator follows the inverse of the fed-back level at once
	assign data_o = cmp_en_i ? ~dev_clk_i : bit_q;
endmodule : sdcd_mod_model

/* sdcd_top_test.sv */
// sdcd_top_test: self-checking bench for sdcd_top.
// assumes sdcd_pkg, sdcd_mod_model and the bound checker are compiled.
`timescale 1ns/10ps
module sdcd_top_test;
	localparam int unsigned NCH = 8;
	localparam logic [7:0] MA = sdcd_pkg::OFS_GROUP_A_MODE_SETTING;
	localparam logic [7:0] MB = sdcd_pkg::OFS_GROUP_B_MODE_SETTING;
	localparam logic [7:0] FA = sdcd_pkg::OFS_GROUP_A_CLOCK_FREQUENCY;
	localparam logic [7:0] FB = sdcd_pkg::OFS_GROUP_B_CLOCK_FREQUENCY;
	localparam logic [7:0] DA = sdcd_pkg::OFS_GROUP_A_DECIMATION;
	localparam logic [7:0] DB = sdcd_pkg::OFS_GROUP_B_DECIMATION;
	localparam logic [7:0] RB = sdcd_pkg::OFS_RAW_BASE;
	localparam logic [1:0] OK = sdcd_pkg::RESP_OKAY;
	localparam logic [1:0] SE = sdcd_pkg::RESP_SLVERR;
	logic clk, rst, awv, wv, bready, arv, rready, own_en, cmp_en;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, v;
	logic [3:0] wstrb, ev;
	logic [1:0] bresp, rresp;
	logic [NCH-1:0] lvl, ibit, pin_o, pin_oe, stb, pq, m_clk, m_dat, pin;
	logic [NCH*16-1:0] raw;
	int cyc, err_total, n_compared, r, gap[4], last[4];

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// released pin shows a changing pattern, never a held level
	assign pin = (pin_oe & pin_o) | (~pin_oe & (own_en ? m_clk : {NCH{cyc[0]}}));
	assign ev = {pin_o[7] & ~pq[7], pin_o[0] & ~pq[0], stb[7], stb[0]};

	sdcd_top u_dut (.MCLK_I(clk), .SYS_RST_I(rst),
		.AXI_AWADDR_I(awaddr), .AXI_AWVALID_I(awv), .AXI_AWREADY_O(awready),
		.AXI_WDATA_I(wdata), .AXI_WSTRB_I(wstrb), .AXI_WVALID_I(wv),
		.AXI_WREADY_O(wready), .AXI_BRESP_O(bresp), .AXI_BVALID_O(bvalid),
		.AXI_BREADY_I(bready), .AXI_ARADDR_I(araddr), .AXI_ARVALID_I(arv),
		.AXI_ARREADY_O(arready), .AXI_RDATA_O(rdata), .AXI_RRESP_O(rresp),
		.AXI_RVALID_O(rvalid), .AXI_RREADY_I(rready),
		.CHANNEL_INPUT_PIN_I(m_dat), .INT_MOD_BIT_I(ibit),
		.MOD_CLK_PIN_I(pin), .MOD_CLK_PIN_O(pin_o),
		.MOD_CLK_PIN_OE_O(pin_oe), .RAW_SAMPLE_O(raw),
		.SAMPLE_STROBE_O(stb));
	sdcd_mod_model #(.NCH(NCH)) u_mod (.dev_clk_i(pin), .own_clk_en_i(own_en),
		.cmp_en_i(cmp_en), .level_i(lvl), .clk_o(m_clk), .data_o(m_dat));

	// ***********************************************************
	// monitors: strobe and pin clock spacing, hang limit
	// ***********************************************************
	always @(posedge clk) begin
		pq <= pin_o;
		cyc <= cyc + 1;
		for (int i = 0; i < 4; i++) begin
			if (ev[i] === 1'b1) begin
				gap[i] <= cyc - last[i];
				last[i] <= cyc;
			end
		end
		if (cyc == 20000) begin
			err_total++;
			complete_run();
		end
	end

	// ***********************************************************
	// model, checks and bus tasks
	// ***********************************************************
	// steady sinc3 output for an all-ones stream
	function automatic logic [15:0] full_scale(input int n);
		int c, f;
		c = 0;
		while ((1 << c) < n) c++;
		f = n * n * n;
		f = (3 * c >= 16) ? f >> (3 * c - 16) : f << (16 - 3 * c);
		return (f > 65535) ? 16'hFFFF : f[15:0];
	endfunction : full_scale
	task automatic fail(input string s);
		err_total++;
		$display("CHECK FAILED t=%0t %s", $time, s);
	endtask : fail
	task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) fail($sformatf("reg %h exp %h", g, e));
	endtask : chk_reg
	task automatic chk_raw(input logic [15:0] g, input logic [15:0] lo,
		input logic [15:0] hi);
		n_compared++;
		if ((^g === 1'bx) || g < lo || g > hi) fail($sformatf("raw %h", g));
	endtask : chk_raw
	task automatic chk_gap(input int g, input int lo, input int hi);
		n_compared++;
		if (g < lo || g > hi) fail($sformatf("gap %0d", g));
	endtask : chk_gap
	task automatic wait_stb(input int c, input int n);
		repeat (n) begin
			@(posedge clk);
			while (stb[c] !== 1'b1) @(posedge clk);
		end
		#1;
	endtask : wait_stb
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [1:0] er);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge clk);
			if (awv && awready) awv <= 1'b0;
			if (wv && wready) wv <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		bready <= 1'b0;
		chk_reg({30'h0, bresp}, {30'h0, er});
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		@(posedge clk);
		araddr <= a;
		arv <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge clk);
			if (arv && arready) arv <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		rready <= 1'b0;
		chk_reg(rdata, e);
		chk_reg({30'h0, rresp}, {30'h0, er});
	endtask : rd
	task automatic complete_run;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : complete_run

	// ***********************************************************
	// main sequence
	// ***********************************************************
	initial begin
		{rst, awv, wv, bready, arv, rready, own_en, cmp_en} = 8'h80;
		{awaddr, araddr, wdata, wstrb} = '0;
		lvl = '1;
		ibit = '0;
		void'($urandom(77));
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rd(MA, 32'h0000_0000, OK);
		rd(FB, 32'h2000_0000, OK);
		rd(DB, 32'h0000_014B, OK);
		rd(8'h20, 32'h0000_0000, SE);
		wr(8'h20, 32'h0000_0001, 4'hF, SE);
		wr(RB, 32'h0000_1234, 4'hF, SE);
		wr(FA, 32'hFFFF_FFFF, 4'h1, OK);
		rd(FA, 32'h2000_00FF, OK);
		wr(FA, 32'h2000_0000, 4'hF, OK);
		wr(MA, 32'hFFFF_FFF0, 4'hF, OK);
		rd(MA, 32'h0000_0000, OK);
		$display("registers done");
		for (int m = 0; m < 4; m++) begin
			wr(MA, 32'(m), 4'hF, OK);
			@(posedge clk);
			chk_reg({30'h0, pin_oe[7], pin_oe[0]}, {31'h0, m[0]});
		end
		$display("modes done");
		wr(MB, 32'h0000_0001, 4'hF, OK);
		wr(FB, 32'h1000_0000, 4'hF, OK);
		wr(DA, 32'h0000_0004, 4'hF, OK);
		wr(DB, 32'h0000_0004, 4'hF, OK);
		wr(MA, 32'h0000_0001, 4'hF, OK);
		wait_stb(0, 4);
		wait_stb(7, 2);
		chk_gap(gap[2], 4, 4);
		chk_gap(gap[3], 8, 8);
		chk_gap(gap[0], 16, 16);
		chk_gap(gap[1], 32, 32);
		chk_raw(raw[15:0], full_scale(4), full_scale(4));
		rd(RB, {16'h0, full_scale(4)}, OK);
		r = 2 + $urandom % 15;
		wr(DA, 32'(r), 4'hF, OK);
		wait_stb(0, 4);
		chk_gap(gap[0], 4 * r, 4 * r);
		chk_raw(raw[15:0], full_scale(r), full_scale(r));
		$display("clock out done");
		wr(MA, 32'h0000_0009, 4'hF, OK);
		wait_stb(0, 4);
		chk_raw(raw[15:0], 16'h0000, 16'h0000);
		wr(MA, 32'h0000_0005, 4'hF, OK);
		wait_stb(0, 4);
		chk_raw(raw[15:0], full_scale(r), full_scale(r));
		chk_gap(gap[2], 4, 4);
		$display("polarity done");
		v = $urandom;
		ibit <= v[7:0];
		wr(MA, 32'h0000_0000, 4'hF, OK);
		wait_stb(0, 4);
		for (int c = 0; c < 5; c++)
			chk_raw(raw[16*c +: 16], v[c] ? full_scale(r) : 16'h0,
				v[c] ? full_scale(r) : 16'h0);
		chk_reg({22'h0, pin_oe[4:0], pin_o[4:0]}, 32'h0000_0000);
		$display("analog done");
		v = $urandom;
		lvl <= v[7:0];
		own_en <= 1'b1;
		wr(MA, 32'h0000_0002, 4'hF, OK);
		wait_stb(0, 4);
		chk_gap(gap[0], r * 92 / 10 - 2, r * 92 / 10 + 2);
		for (int c = 0; c < 5; c++)
			chk_raw(raw[16*c +: 16], v[c] ? full_scale(r) : 16'h0,
				v[c] ? full_scale(r) : 16'h0);
		$display("clock in done");
		own_en <= 1'b0;
		cmp_en <= 1'b1;
		wr(DA, 32'h0000_0008, 4'hF, OK);
		wr(MA, 32'h0000_0003, 4'hF, OK);
		wait_stb(0, 4);
		chk_raw(raw[15:0], 16'h4000, 16'hC000);
		$display("comparator done");
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		chk_raw(raw[15:0], 16'h0000, 16'h0000);
		rd(DA, 32'h0000_014B, OK);
		rd(MB, 32'h0000_0000, OK);
		$display("reset done");
		complete_run();
	end
endmodule : sdcd_top_test
